// *** pmreg_pkg.sv ***
// pmreg_pkg: constants and carrier types for the management register bank
// assumes: used by pmreg_mdio_slave and pmreg_bank, no other dependency
package pmreg_pkg;

  // register indices on the management bus
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS  = 5'h01;
  localparam logic [4:0] REG_IDENT_H = 5'h02;
  localparam logic [4:0] REG_IDENT_L = 5'h03;
  localparam logic [4:0] REG_ADVERT  = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_EXPAND  = 5'h06;

  // control bit positions
  localparam int CTL_SPEED_MSB  = 6;
  localparam int CTL_COL_TEST   = 7;
  localparam int CTL_DUPLEX     = 8;
  localparam int CTL_RESTART_AN = 9;
  localparam int CTL_ISOLATE    = 10;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_AN_ENABLE  = 12;
  localparam int CTL_SPEED_LSB  = 13;
  localparam int CTL_LOOPBACK   = 14;
  localparam int CTL_SW_RESET   = 15;

  // status bit positions
  localparam int STS_JABBER  = 1;
  localparam int STS_LINK    = 2;
  localparam int STS_RFAULT  = 4;
  localparam int STS_AN_DONE = 5;

  // hardware reset values
  localparam logic [15:0] CONTROL_HW_RESET = 16'h1140;
  localparam logic [15:0] ADVERT_HW_RESET  = 16'h05e1;
  // writable masks
  localparam logic [15:0] CONTROL_WR_MASK  = 16'hffc0;
  localparam logic [15:0] ADVERT_WR_MASK   = 16'hade0;
  // control bits kept through a software reset
  localparam logic [15:0] CONTROL_SW_KEEP  = 16'h3140;

  // fixed parts
  localparam logic [15:0] STATUS_FIXED     = 16'h7949;
  localparam logic [4:0]  ADVERT_SELECTOR  = 5'h01;

  // frame fields
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int         FRAME_BITS = 32;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
  } pmreg_req_t;

  typedef struct packed {
    logic        link_up;
    logic        jabber;
    logic        remote_fault;
    logic        an_complete;
    logic        partner_an_able;
    logic [15:0] partner_word;
  } pmreg_line_t;

endpackage

// *** pmreg_mdio_slave.sv ***
// pmreg_mdio_slave: serial management frame receiver and read shifter
// assumes: mdc and mdio input already synchronised to i_clk by the caller
`timescale 1ns/1ns
module pmreg_mdio_slave (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_ce,
  input  wire logic               i_mdc_rise,
  input  wire logic               i_mdio,
  input  wire logic [4:0]         i_phy_addr,
  input  wire logic [15:0]        i_rdata,
  output pmreg_pkg::pmreg_req_t   o_req,
  output logic                    o_rd_done,
  output logic                    o_mdio_out,
  output logic                    o_mdio_oe
);

  typedef enum logic [1:0] {PMREG_IDLE, PMREG_HEAD, PMREG_READ,
                            PMREG_WRITE} pmreg_state_t;

  pmreg_state_t state;
  logic [13:0]  head;
  logic [4:0]   count;
  logic [15:0]  shift;
  logic         mine;
  logic         load;

  // preamble is optional: a 0 then 1 start is seen after any idle ones
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state      <= PMREG_IDLE;
      head       <= 14'h3fff;
      count      <= 5'h00;
      shift      <= 16'h0000;
      mine       <= 1'b0;
      load       <= 1'b0;
      o_req      <= '0;
      o_rd_done  <= 1'b0;
      o_mdio_out <= 1'b0;
      o_mdio_oe  <= 1'b0;
    end else if (i_ce) begin
      o_req.valid <= 1'b0;
      o_rd_done   <= 1'b0;
      load        <= 1'b0;
      // read data is taken one clock after the header decode, once the
      // new register index has reached the bank's read mux
      if (load) begin
        shift      <= i_rdata;
        o_mdio_out <= i_rdata[15];
        o_mdio_oe  <= 1'b1;
      end
      if (i_mdc_rise) begin
        case (state)
          PMREG_IDLE: begin
            head <= {head[12:0], i_mdio};
            if (!head[0] && i_mdio) begin
              state <= PMREG_HEAD;
              count <= 5'h00;
            end
          end
          PMREG_HEAD: begin
            head  <= {head[12:0], i_mdio};
            count <= count + 5'h01;
            if (count == 5'd13) begin
              // head holds op(2) phy(5) reg(5) and the first ta bit
              mine           <= (head[10:6] == i_phy_addr);
              o_req.reg_addr <= head[5:1];
              o_req.write    <= (head[12:11] == pmreg_pkg::OP_WRITE);
              count          <= 5'h00;
              if (head[10:6] == i_phy_addr &&
                  head[12:11] == pmreg_pkg::OP_READ) begin
                state <= PMREG_READ;
                load  <= 1'b1;
              end else begin
                // foreign or odd frames are skipped whole, so that
                // their data bits cannot pose as a start
                state <= PMREG_WRITE;
              end
            end
          end
          PMREG_READ: begin
            shift      <= {shift[14:0], 1'b0};
            o_mdio_out <= shift[14];
            count      <= count + 5'h01;
            if (count == 5'd15) begin
              o_mdio_oe <= 1'b0;
              o_rd_done <= mine;
              state     <= PMREG_IDLE;
              head      <= 14'h3fff;
            end
          end
          PMREG_WRITE: begin
            shift <= {shift[14:0], i_mdio};
            count <= count + 5'h01;
            if (count == 5'd15) begin
              o_req.valid <= mine && o_req.write;
              o_req.wdata <= {shift[14:0], i_mdio};
              state       <= PMREG_IDLE;
              head        <= 14'h3fff;
            end
          end
          default: state <= PMREG_IDLE;
        endcase
      end
    end
  end

endmodule

// *** pmreg_bank.sv ***
// pmreg_bank: management register bank of the transceiver
// assumes: one clock i_clk at 250 MHz; mdc far slower, sampled as data;
// line-side conditions arrive from logic on the same clock
`timescale 1ns/1ns

module pmreg_bank #(
  parameter logic [15:0] IDENT_HIGH = 16'h1234, // arbitrary value
  parameter logic [5:0]  IDENT_OUI  = 6'h15,    // arbitrary value
  parameter logic [5:0]  IDENT_MODEL = 6'h2a,   // arbitrary value
  parameter logic [3:0]  IDENT_REV  = 4'h1      // arbitrary value
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_ce,
  input  wire logic [2:0]             i_strap,
  input  wire logic                   i_mdc,
  input  wire logic                   i_mdio,
  input  wire pmreg_pkg::pmreg_line_t i_line,
  output logic                        o_mdio,
  output logic                        o_mdio_oe,
  output logic [1:0]                  o_speed,
  output logic                        o_full_duplex,
  output logic                        o_col_test,
  output logic                        o_an_enable,
  output logic                        o_an_restart,
  output logic                        o_isolate,
  output logic                        o_power_down,
  output logic                        o_loopback,
  output logic                        o_soft_reset
);

  logic [1:0]  mdc_sync;
  logic [1:0]  mdio_sync;
  logic        mdc_prev;
  logic [2:0]  strap_s1;
  logic [2:0]  strap_s2;
  logic        strap_taken;
  logic [4:0]  phy_addr;
  logic [15:0] control;
  logic [15:0] advert;
  logic        link_ll;
  logic        jabber_lh;
  logic        rfault_lh;
  logic        mdc_rise;
  logic [15:0] rdata;
  logic        rd_done;
  logic        sw_reset;
  pmreg_pkg::pmreg_req_t req;

  function automatic logic [15:0] wr_merge(input logic [15:0] cur,
                                           input logic [15:0] wd,
                                           input logic [15:0] mask);
    wr_merge = (cur & ~mask) | (wd & mask);
  endfunction

  // pins cross two flops; the edge detector reads only the second stage
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mdc_sync  <= 2'h0;
      mdio_sync <= 2'h3;
      mdc_prev  <= 1'b0;
    end else if (i_ce) begin
      mdc_sync  <= {mdc_sync[0], i_mdc};
      mdio_sync <= {mdio_sync[0], i_mdio};
      mdc_prev  <= mdc_sync[1];
    end
  end

  // straps keep sampling under reset so the pin level is ready at release
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      strap_s1 <= i_strap;
      strap_s2 <= strap_s1;
    end
  end

  assign mdc_rise = mdc_sync[1] && !mdc_prev;

  // strap is caught by a clock after release, never under reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      strap_taken <= 1'b0;
      phy_addr    <= 5'h00;
    end else if (i_ce && !strap_taken) begin
      strap_taken <= 1'b1;
      phy_addr    <= {2'h0, strap_s2[2], ~strap_s2[1:0]};
    end
  end

  // the first valid read must wait until the strap settles
  pmreg_mdio_slave u_slave (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_ce       (i_ce),
    .i_mdc_rise (mdc_rise && strap_taken),
    .i_mdio     (mdio_sync[1]),
    .i_phy_addr (phy_addr),
    .i_rdata    (rdata),
    .o_req      (req),
    .o_rd_done  (rd_done),
    .o_mdio_out (o_mdio),
    .o_mdio_oe  (o_mdio_oe)
  );

  assign sw_reset = control[pmreg_pkg::CTL_SW_RESET];

  // control: software reset takes one cycle, then self-clears
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      control <= pmreg_pkg::CONTROL_HW_RESET;
    end else if (i_ce) begin
      if (sw_reset) begin
        control <= (control & pmreg_pkg::CONTROL_SW_KEEP);
      end else if (req.valid && req.reg_addr == pmreg_pkg::REG_CONTROL) begin
        control <= wr_merge(control, req.wdata,
                            pmreg_pkg::CONTROL_WR_MASK);
      end else begin
        control[pmreg_pkg::CTL_RESTART_AN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      advert <= pmreg_pkg::ADVERT_HW_RESET;
    end else if (i_ce) begin
      if (sw_reset) begin
        advert <= pmreg_pkg::ADVERT_HW_RESET;
      end else if (req.valid && req.reg_addr == pmreg_pkg::REG_ADVERT) begin
        advert <= wr_merge(advert, req.wdata,
                           pmreg_pkg::ADVERT_WR_MASK);
      end
    end
  end

  // latches: new events win over the read clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      link_ll   <= 1'b0;
      jabber_lh <= 1'b0;
      rfault_lh <= 1'b0;
    end else if (i_ce) begin
      if (sw_reset) begin
        link_ll   <= 1'b0;
        jabber_lh <= 1'b0;
        rfault_lh <= 1'b0;
      end else if (rd_done && req.reg_addr == pmreg_pkg::REG_STATUS) begin
        link_ll   <= i_line.link_up;
        jabber_lh <= i_line.jabber;
        rfault_lh <= i_line.remote_fault;
      end else begin
        link_ll   <= link_ll & i_line.link_up;
        jabber_lh <= jabber_lh | i_line.jabber;
        rfault_lh <= rfault_lh | i_line.remote_fault;
      end
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rdata = 16'h0000;
    case (req.reg_addr)
      pmreg_pkg::REG_CONTROL: rdata = control;
      pmreg_pkg::REG_STATUS: begin
        rdata = pmreg_pkg::STATUS_FIXED;
        rdata[pmreg_pkg::STS_JABBER]  = jabber_lh;
        rdata[pmreg_pkg::STS_LINK]    = link_ll;
        rdata[pmreg_pkg::STS_RFAULT]  = rfault_lh;
        rdata[pmreg_pkg::STS_AN_DONE] = i_line.an_complete;
      end
      pmreg_pkg::REG_IDENT_H: rdata = IDENT_HIGH;
      pmreg_pkg::REG_IDENT_L: rdata = {IDENT_OUI, IDENT_MODEL,
                                       IDENT_REV};
      pmreg_pkg::REG_ADVERT: rdata = {advert[15:5],
                                      pmreg_pkg::ADVERT_SELECTOR};
      pmreg_pkg::REG_PARTNER: rdata = i_line.partner_word;
      pmreg_pkg::REG_EXPAND: rdata = {15'h0000,
                                      i_line.partner_an_able};
      default: rdata = 16'h0000;
    endcase
  end

  // every output is a flop
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_speed       <= 2'h2;
      o_full_duplex <= 1'b1;
      o_col_test    <= 1'b0;
      o_an_enable   <= 1'b1;
      o_an_restart  <= 1'b0;
      o_isolate     <= 1'b0;
      o_power_down  <= 1'b0;
      o_loopback    <= 1'b0;
      o_soft_reset  <= 1'b0;
    end else if (i_ce) begin
      o_speed       <= {control[pmreg_pkg::CTL_SPEED_MSB],
                        control[pmreg_pkg::CTL_SPEED_LSB]};
      o_full_duplex <= control[pmreg_pkg::CTL_DUPLEX];
      o_col_test    <= control[pmreg_pkg::CTL_COL_TEST];
      o_an_enable   <= control[pmreg_pkg::CTL_AN_ENABLE];
      o_an_restart  <= control[pmreg_pkg::CTL_RESTART_AN];
      o_isolate     <= control[pmreg_pkg::CTL_ISOLATE];
      o_power_down  <= control[pmreg_pkg::CTL_POWER_DOWN];
      o_loopback    <= control[pmreg_pkg::CTL_LOOPBACK];
      o_soft_reset  <= sw_reset;
    end
  end

endmodule

// *** pmreg_props.sv ***
// pmreg_props: port-level checks for pmreg_bank
// assumes: bound to pmreg_bank, i_ce low only between frames, mdc slow
`timescale 1ns/1ns
module pmreg_props (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_mdc,
  input wire logic       o_mdio_oe,
  input wire logic [1:0] o_speed,
  input wire logic       o_full_duplex,
  input wire logic       o_col_test,
  input wire logic       o_an_enable,
  input wire logic       o_an_restart,
  input wire logic       o_isolate,
  input wire logic       o_power_down,
  input wire logic       o_loopback,
  input wire logic       o_soft_reset
);
  logic       mdc_q;
  logic [4:0] n_rise;
  logic [4:0] age;
  logic [7:0] ctl;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  assign ctl = {o_speed, o_full_duplex, o_col_test, o_an_enable,
                o_isolate, o_power_down, o_loopback};
  always_ff @(posedge i_clk) mdc_q <= i_mdc;
  // mdc rises counted while the read driver is on
  always_ff @(posedge i_clk) begin
    if (!o_mdio_oe) n_rise <= 5'h00;
    else if (i_mdc && !mdc_q) n_rise <= n_rise + 5'h01;
  end
  // saturating age since the last mdc rise at the pin
  always_ff @(posedge i_clk) begin
    if (i_mdc && !mdc_q) age <= 5'h00;
    else if (age != 5'h1f) age <= age + 5'h01;
  end
  reset_vals_a: assert property (
    $rose(i_resetn) |-> o_speed == 2'b10 && o_full_duplex && o_an_enable
      && !o_mdio_oe && !o_col_test && !o_isolate && !o_loopback)
    else $error("control outputs wrong after reset");
  soft_pulse_a: assert property (
    o_soft_reset |=> !o_soft_reset)
    else $error("soft reset not self clearing");
  restart_clear_a: assert property (
    o_an_restart |-> ##[1:3] !o_an_restart)
    else $error("restart not self clearing");
  soft_clear_a: assert property (
    o_soft_reset |-> ##2 !o_col_test && !o_isolate && !o_power_down
      && !o_loopback)
    else $error("soft reset left control bits set");
  soft_keep_a: assert property (
    o_soft_reset |-> ##2 o_speed == $past(o_speed, 2)
      && o_full_duplex == $past(o_full_duplex, 2)
      && o_an_enable == $past(o_an_enable, 2))
    else $error("soft reset changed kept bits");
  read_len_a: assert property (
    $fell(o_mdio_oe) |-> n_rise == 5'd16)
    else $error("read driver length wrong");
  oe_hold_a: assert property (
    $rose(o_mdio_oe) |-> o_mdio_oe[*8])
    else $error("read driver dropped early");
  ctl_cause_a: assert property (
    $changed(ctl) |-> age < 5'd12)
    else $error("control output moved without a frame");
endmodule

// *** pmreg_mgmt_master.sv ***
// pmreg_mgmt_master: station management master model on mdc and mdio
// assumes: bench resolves mdio with a pull-up; mdc idles low between frames
`timescale 1ns/1ns
module pmreg_mgmt_master #(
  parameter int HALF = 10
) (
  input  wire logic i_clk,
  input  wire logic i_mdio,
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // data moves while mdc is low, sampled just before the rise
  task automatic tick(input logic oe, input logic d, output logic smp);
    o_mdio_oe = oe;
    o_mdio = d;
    repeat (HALF) @(negedge i_clk);
    smp = i_mdio;
    o_mdc = 1'b1;
    repeat (HALF) @(negedge i_clk);
    o_mdc = 1'b0;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [31:0] w;
    logic        rdop;
    logic        s;
    w = {2'b01, op, phy, ra, 2'b10, wd};
    rdop = (op == 2'b10);
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      tick(!(rdop && i >= 14), w[31-i], s);
      if (i >= 16) rd[31-i] = s;
    end
    // released idle clock gives the 33rd mdc cycle
    tick(1'b0, 1'b1, s);
  endtask
endmodule

// *** pmreg_bank_test.sv ***
// pmreg_bank_test: self-checking bench for the management register bank
// assumes: mdio pulled up to 1 here; line conditions driven by the bench
`timescale 1ns/1ns
module pmreg_bank_test;
  logic                   i_clk = 1'b0;
  logic                   i_resetn = 1'b0;
  logic                   i_ce = 1'b1;
  logic [2:0]             i_strap = 3'h0;
  logic                   i_mdc;
  logic                   i_mdio;
  pmreg_pkg::pmreg_line_t i_line = '0;
  logic                   o_mdio, o_mdio_oe, o_full_duplex, o_col_test;
  logic                   o_an_enable, o_an_restart, o_isolate;
  logic                   o_power_down, o_loopback, o_soft_reset;
  logic [1:0]             o_speed;
  logic                   m_out, m_oe;
  logic [4:0]             addr;
  int                     seed = 10897;
  int                     n_mismatch = 0;
  int                     compares = 0;
  int                     n_soft = 0;
  int                     n_restart = 0;
  always #2 i_clk = ~i_clk;
  assign i_mdio = o_mdio_oe ? o_mdio : (m_oe ? m_out : 1'b1);
  always @(posedge i_clk) begin
    n_soft += o_soft_reset;
    n_restart += o_an_restart;
  end
  pmreg_bank #(.IDENT_HIGH(16'h5a5a), .IDENT_OUI(6'h2c), // arbitrary values
    .IDENT_MODEL(6'h13), .IDENT_REV(4'h7)) u_pmreg_bank (.i_clk, .i_resetn,
    .i_ce, .i_strap, .i_mdc, .i_mdio, .i_line, .o_mdio, .o_mdio_oe,
    .o_speed, .o_full_duplex, .o_col_test, .o_an_enable, .o_an_restart,
    .o_isolate, .o_power_down, .o_loopback, .o_soft_reset);
  pmreg_mgmt_master u_pmreg_mgmt_master (.i_clk, .i_mdio, .o_mdc(i_mdc),
    .o_mdio(m_out), .o_mdio_oe(m_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] d,
                      output logic [15:0] r);
    u_pmreg_mgmt_master.frame(op, pa, ra, d, r);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] r;
    xfer(2'b01, addr, ra, d, r);
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] r);
    xfer(2'b10, addr, ra, 16'h0000, r);
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(negedge i_clk);
    i_strap = s;
    i_resetn = 1'b0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    addr = {2'b00, s[2], ~s[1:0]};
    repeat (4) @(negedge i_clk);
  endtask
  function automatic logic [15:0] sts(input logic lk, jb, rf, an);
    sts = 16'h7949 | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
  endfunction
  // whole map, with the line quiet so status shows no events
  task automatic chk_map(input logic [15:0] c, input logic [15:0] a);
    logic [15:0] e [7];
    logic [15:0] r;
    e = '{c, sts(1'b0, 1'b0, 1'b0, 1'b0), 16'h5a5a, {6'h2c, 6'h13, 4'h7},
          a, i_line.partner_word, {15'h0000, i_line.partner_an_able}};
    for (int k = 0; k < 7; k++) begin
      rd(k[4:0], r);
      chk(r, e[k]);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done, mismatches %0d", s, n_mismatch);
  endtask
  initial begin
    #360000;
    n_mismatch++;
    final_report;
  end
  initial begin
    logic [15:0] r, w, c;
    i_line.partner_word = 16'($random(seed));
    do_reset(3'($random(seed)));
    chk_map(16'h1140, 16'h05e1);
    done("defaults");
    xfer(2'b01, addr ^ 5'h10, 5'h00, 16'h0000, r);
    xfer(2'b10, addr ^ 5'h04, 5'h00, 16'h0000, r);
    chk(r, 16'hffff);
    xfer(2'b00, addr, 5'h00, 16'h0000, r);
    xfer(2'b11, addr, 5'h00, 16'h0000, r);
    chk_map(16'h1140, 16'h05e1);
    done("refused");
    for (int k = 0; k < 12; k++) begin
      w = 16'($random(seed)) & 16'h7dff;
      {w[6], w[13]} = k[1:0];
      wr(pmreg_pkg::REG_CONTROL, w);
      c = w & 16'hffc0;
      chk({14'h0000, o_speed}, {14'h0000, k[1:0]});
      chk({o_loopback, o_an_enable, o_power_down, o_isolate, o_full_duplex,
           o_col_test}, {w[14], w[12], w[11], w[10], w[8], w[7]});
      rd(pmreg_pkg::REG_CONTROL, r);
      chk(r, c);
      w = 16'($random(seed));
      wr(pmreg_pkg::REG_ADVERT, w);
      rd(pmreg_pkg::REG_ADVERT, r);
      chk(r, (w & 16'hade0) | 16'h0001);
    end
    for (int k = 1; k < 8; k++) if (k != 4) wr(k[4:0], 16'hffff);
    wr(5'h1f, 16'hffff);
    chk_map(c, (w & 16'hade0) | 16'h0001);
    done("writes");
    wr(pmreg_pkg::REG_CONTROL, 16'h1340);
    rd(pmreg_pkg::REG_CONTROL, r);
    chk(r, 16'h1140);
    chk({15'h0000, n_restart != 0}, 16'h0001);
    wr(pmreg_pkg::REG_ADVERT, 16'h0000);
    w = 16'($random(seed)) | 16'h8000;
    wr(pmreg_pkg::REG_CONTROL, w & 16'hfdff);
    chk(16'(n_soft), 16'h0001);
    chk_map(w & 16'h3140, 16'h05e1);
    done("self clearing");
    i_ce = 1'b0;
    wr(pmreg_pkg::REG_CONTROL, 16'h0000);
    i_ce = 1'b1;
    rd(pmreg_pkg::REG_CONTROL, r);
    chk(r, w & 16'h3140);
    done("frozen");
    @(negedge i_clk);
    i_line.link_up = 1'b1;
    i_line.an_complete = 1'b1;
    i_line.partner_an_able = 1'b1;
    rd(pmreg_pkg::REG_STATUS, r);
    chk(r, sts(1'b0, 1'b0, 1'b0, 1'b1));
    rd(pmreg_pkg::REG_STATUS, r);
    chk(r, sts(1'b1, 1'b0, 1'b0, 1'b1));
    i_line.link_up = 1'b0;
    i_line.jabber = 1'b1;
    i_line.remote_fault = 1'b1;
    repeat (5) @(negedge i_clk);
    i_line = {1'b1, 3'h0, 1'b1, i_line.partner_word};
    rd(pmreg_pkg::REG_STATUS, r);
    chk(r, sts(1'b0, 1'b1, 1'b1, 1'b0));
    rd(pmreg_pkg::REG_STATUS, r);
    chk(r, sts(1'b1, 1'b0, 1'b0, 1'b0));
    rd(pmreg_pkg::REG_EXPAND, r);
    chk(r, 16'h0001);
    done("latches");
    i_line = {5'h00, 16'($random(seed))};
    do_reset(3'b111);
    i_strap = 3'b000;
    chk_map(16'h1140, 16'h05e1);
    done("straps");
    final_report;
  end
endmodule
bind pmreg_bank pmreg_props u_pmreg_props (.i_clk, .i_resetn, .i_mdc,
  .o_mdio_oe, .o_speed, .o_full_duplex, .o_col_test, .o_an_enable,
  .o_an_restart, .o_isolate, .o_power_down, .o_loopback, .o_soft_reset);
